// *** rtl/rtc_spr.sv ***
// seconds/nanoseconds clock, nanosecond down counter and special-register move decode
// Notes on behaviour
// RULE_01: the clock is 64 bits, an upper seconds word and a lower nanoseconds word.
// RULE_02: seconds gain one whenever nanoseconds pass 999_999_999.
// RULE_03: on that carry nanoseconds restart from zero so they never exceed the limit.
// RULE_04: software reaches both clock words only through move-to and move-from operations by number; the bus also reads them at ADDR_SECONDS/ADDR_NSEC.
// RULE_05: the clock word numbers are accepted as valid numbers.
// RULE_06: the clock advances at least once within a short run of add-immediate instructions.
// RULE_07: low nanosecond bits may be left out, so the word steps coarser than one nanosecond.
// RULE_08: the down counter falls at the nanosecond rate of the clock.
// RULE_09: some down counter bits may be left unimplemented.
// RULE_10: the move number field decoded is 10 bits wide, the old form used 5.
// RULE_11: an undefined number is an invalid form, and in user mode supervisor numbers count as undefined.
// RULE_12: an undefined number changes no register and raises a program exception in user mode when bit 0 is set.
// RULE_13: a low field of 0 accesses the multiply-quotient register.
// RULE_14: a move-from with low field 6 reads the down counter, also from user mode.
// RULE_15: clock word writes need supervisor state; user mode may only read them.
`timescale 1ns/1ns
`default_nettype none
module rtc_spr #(
    parameter int NSEC_DROP_BITS = 0,  // unimplemented low nanosecond bits
    parameter int DCNT_BITS      = 32  // implemented down counter bits
) (
    input  wire logic            sys_clk_i,
    input  wire logic            resetn_i,
    input  wire logic            clk_en_i,
    input  wire rtc_pkg::av_req_t av_req_i,
    output var  rtc_pkg::av_rsp_t av_rsp_o,
    output logic                 irq_o
);
    import rtc_pkg::*;

    rtc_state_t q;
    rtc_state_t next_q;

    logic [31:0] nsec_sum;
    logic [31:0] dcnt_mask;
    logic [31:0] nsec_mask;
    logic [9:0]  num;
    logic        is_wr;
    logic        is_sup;
    logic        valid;
    logic        acc;
    logic [IRQ_W-1:0] ev;  // hardware events of this cycle

    assign dcnt_mask = (DCNT_BITS >= 32) ? 32'hffff_ffff : ((32'h1 << DCNT_BITS) - 32'h1); // [RULE_09]
    assign nsec_mask = ~((32'h1 << NSEC_DROP_BITS) - 32'h1);                             // [RULE_07]
    assign av_rsp_o  = q.rsp;
    assign irq_o     = q.irq;

    always_comb begin
        next_q = q;
        acc    = 1'b0;
        ev     = '0;
        num    = av_req_i.writedata[SPRN_W-1:0];
        is_wr  = av_req_i.writedata[CMD_WR_BIT];
        is_sup = av_req_i.writedata[CMD_SUP_BIT];
        valid  = 1'b0;

        // time keeping: one clock period of nanoseconds per cycle, well within any short instruction run
        nsec_sum = q.nanoseconds + NSEC_STEP;                                  // [RULE_06] [RULE_08]
        if (nsec_sum > NSEC_LIMIT) begin                                       // [RULE_01]
            next_q.seconds     = q.seconds + 32'h1;                            // [RULE_02]
            next_q.nanoseconds = 32'h0;                                        // [RULE_03]
            next_q.irq_stat[IRQ_CARRY] = 1'b1;
            ev[IRQ_CARRY] = 1'b1;
        end else begin
            next_q.nanoseconds = nsec_sum & nsec_mask;                         // [RULE_07]
        end
        if (q.down_count < NSEC_STEP) begin
            next_q.irq_stat[IRQ_UNDER] = 1'b1;
            ev[IRQ_UNDER] = 1'b1;
        end
        next_q.down_count = (q.down_count - NSEC_STEP) & dcnt_mask;            // [RULE_08] [RULE_09]

        // bus slave answers in the cycle after a request; waitrequest high otherwise
        next_q.rsp.waitrequest = 1'b1;
        if ((av_req_i.read || av_req_i.write) && q.rsp.waitrequest) begin
            acc = 1'b1;
            next_q.rsp.waitrequest = 1'b0;
        end

        if (acc && av_req_i.write) begin
            unique case (av_req_i.address)
                ADDR_CMD: begin
                    next_q.result = 3'h0;
                    if (is_wr) begin
                        // supervisor move-to numbers decode on the full 10-bit field, the MQ move-to on the low 5 bits in either mode
                        if (is_sup && num == SPRN_SEC_WR) begin                // [RULE_04] [RULE_05] [RULE_10] [RULE_15]
                            next_q.seconds = q.wdata;
                            valid = 1'b1;
                        end else if (is_sup && num == SPRN_NSEC_WR) begin      // [RULE_15]
                            next_q.nanoseconds = (q.wdata > NSEC_LIMIT) ? 32'h0 : (q.wdata & nsec_mask);
                            valid = 1'b1;
                        end else if (is_sup && num == SPRN_DCNT) begin
                            next_q.down_count = q.wdata & dcnt_mask;
                            valid = 1'b1;
                        end else if (num[LOW_W-1:0] == LOW_MQ) begin           // [RULE_13]
                            next_q.mq = q.wdata;
                            valid = 1'b1;
                        end
                    end else begin
                        if (num == SPRN_SEC_RD) begin                          // [RULE_04] [RULE_05]
                            next_q.rdata = q.seconds;
                            valid = 1'b1;
                        end else if (num == SPRN_NSEC_RD) begin
                            next_q.rdata = q.nanoseconds;
                            valid = 1'b1;
                        end else if (num[LOW_W-1:0] == LOW_DCNT_USER) begin    // [RULE_14]
                            next_q.rdata = q.down_count;
                            valid = 1'b1;
                        end else if (num[LOW_W-1:0] == LOW_MQ) begin           // [RULE_13]
                            next_q.rdata = q.mq;
                            valid = 1'b1;
                        end else if (is_sup && num == SPRN_DCNT) begin
                            next_q.rdata = q.down_count;
                            valid = 1'b1;
                        end
                    end
                    if (valid) begin
                        next_q.result[RES_OK] = 1'b1;
                    end else begin
                        // nothing architected changes; user mode with bit 0 set traps
                        next_q.result[RES_INVALID] = 1'b1;                     // [RULE_11] [RULE_12]
                        if (!is_sup && num[0]) begin                           // [RULE_12]
                            next_q.result[RES_PROG] = 1'b1;
                            next_q.irq_stat[IRQ_PROG] = 1'b1;
                        end
                    end
                end
                ADDR_WDATA: begin
                    next_q.wdata = av_req_i.writedata;
                end
                ADDR_IRQ_CLR: begin
                    // set wins: clear only bits that no event sets this cycle
                    next_q.irq_stat = (q.irq_stat & ~av_req_i.writedata[IRQ_W-1:0]) | ev;
                end
                ADDR_IRQ_EN: begin
                    next_q.irq_en = av_req_i.writedata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        if (acc && av_req_i.read) begin
            unique case (av_req_i.address)
                ADDR_CMD:      next_q.rsp.readdata = 32'h0;
                ADDR_WDATA:    next_q.rsp.readdata = q.wdata;
                ADDR_RDATA:    next_q.rsp.readdata = q.rdata;
                ADDR_RESULT:   next_q.rsp.readdata = {29'h0, q.result};
                ADDR_IRQ_STAT: next_q.rsp.readdata = {29'h0, q.irq_stat};
                ADDR_IRQ_CLR:  next_q.rsp.readdata = 32'h0;
                ADDR_IRQ_EN:   next_q.rsp.readdata = {29'h0, q.irq_en};
                ADDR_SECONDS:  next_q.rsp.readdata = q.seconds;
                ADDR_NSEC:     next_q.rsp.readdata = q.nanoseconds;
                ADDR_DCOUNT:   next_q.rsp.readdata = q.down_count;
                default:       next_q.rsp.readdata = UNMAPPED_DATA;
            endcase
        end

        next_q.irq = |(next_q.irq_stat & next_q.irq_en);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.rsp.waitrequest <= 1'b1;
        end else if (clk_en_i) begin
            q <= next_q;
        end
    end
endmodule : rtc_spr
`default_nettype wire

// *** rtl/rtc_pkg.sv ***
// package: constants, types and register map of the seconds/nanoseconds clock and down counter
package rtc_pkg;
    localparam int          XLEN            = 32;
    localparam int          SPRN_W          = 10;
    localparam int          LOW_W           = 5;
    // move-from numbers
    localparam logic [9:0]  SPRN_MQ         = 10'h000;
    localparam logic [9:0]  SPRN_SEC_RD     = 10'h004;
    localparam logic [9:0]  SPRN_NSEC_RD    = 10'h005;
    localparam logic [9:0]  SPRN_DCNT_USER  = 10'h006;
    // move-to numbers, supervisor only
    localparam logic [9:0]  SPRN_SEC_WR     = 10'h014;
    localparam logic [9:0]  SPRN_NSEC_WR    = 10'h015;
    localparam logic [9:0]  SPRN_DCNT       = 10'h016;
    localparam logic [4:0]  LOW_MQ          = 5'h00;
    localparam logic [4:0]  LOW_DCNT_USER   = 5'h06;
    localparam logic [31:0] NSEC_LIMIT      = 32'h3b9a_c9ff; // 999_999_999
    localparam int          CLK_PERIOD_NS   = 20;
    localparam logic [31:0] NSEC_STEP       = 32'(CLK_PERIOD_NS);
    // avalon register map
    localparam logic [3:0]  ADDR_CMD        = 4'h0;
    localparam logic [3:0]  ADDR_WDATA      = 4'h1;
    localparam logic [3:0]  ADDR_RDATA      = 4'h2;
    localparam logic [3:0]  ADDR_RESULT     = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_CLR    = 4'h5;
    localparam logic [3:0]  ADDR_IRQ_EN     = 4'h6;
    localparam logic [3:0]  ADDR_SECONDS    = 4'h7;
    localparam logic [3:0]  ADDR_NSEC       = 4'h8;
    localparam logic [3:0]  ADDR_DCOUNT     = 4'h9;
    localparam logic [31:0] UNMAPPED_DATA   = 32'hdead_beef;
    // cmd register: [9:0] number, [16] write, [17] supervisor; writing it executes the move
    localparam int          CMD_WR_BIT      = 16;
    localparam int          CMD_SUP_BIT     = 17;
    // irq bits: 0 seconds carry, 1 down counter underflow, 2 program exception
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_CARRY       = 0;
    localparam int          IRQ_UNDER       = 1;
    localparam int          IRQ_PROG        = 2;
    // result register: [0] done ok, [1] program exception, [2] invalid form
    localparam int          RES_OK          = 0;
    localparam int          RES_PROG        = 1;
    localparam int          RES_INVALID     = 2;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } av_rsp_t;

    typedef struct packed {
        logic [31:0]      seconds;
        logic [31:0]      nanoseconds;
        logic [31:0]      down_count;
        logic [31:0]      mq;
        logic [31:0]      wdata;
        logic [31:0]      rdata;
        logic [2:0]       result;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic             irq;
        av_rsp_t          rsp;
    } rtc_state_t;
endpackage : rtc_pkg

// *** tb/rtc_spr_properties.sv ***
// checker: bus handshake, clock word range, interrupt mask and freeze properties
`timescale 1ns/1ns
`default_nettype none
module rtc_spr_properties
    import rtc_pkg::*;
#(
    parameter int NSEC_DROP_BITS = 0,
    parameter int DCNT_BITS      = 32
) (
    input wire logic             sys_clk_i,
    input wire logic             resetn_i,
    input wire logic             clk_en_i,
    input wire rtc_pkg::av_req_t av_req_i,
    input wire rtc_pkg::av_rsp_t av_rsp_o,
    input wire logic             irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence taken_s;
        clk_en_i && av_rsp_o.waitrequest && (av_req_i.read || av_req_i.write);
    endsequence
    wait_one_a: assert property (taken_s |=> !av_rsp_o.waitrequest)
        else $error("request not answered after one wait cycle");
    answer_once_a: assert property (!av_rsp_o.waitrequest |=> av_rsp_o.waitrequest)
        else $error("waitrequest low longer than one cycle");
    idle_wait_a: assert property (av_rsp_o.waitrequest && !av_req_i.read && !av_req_i.write
        |=> av_rsp_o.waitrequest) else $error("answer without a request");
    unmapped_read_a: assert property (taken_s and (av_req_i.read && av_req_i.address > ADDR_DCOUNT)
        |=> av_rsp_o.readdata == UNMAPPED_DATA) else $error("unmapped read data wrong");
    nsec_range_a: assert property (taken_s and (av_req_i.read && av_req_i.address == ADDR_NSEC)
        |=> av_rsp_o.readdata <= NSEC_LIMIT) else $error("nanoseconds above limit");
    irq_mask_a: assert property (taken_s and (av_req_i.write && av_req_i.address == ADDR_IRQ_EN
        && av_req_i.writedata[2:0] == 3'h0) |=> !irq_o) else $error("irq high with all masked");
    freeze_a: assert property (!clk_en_i |=> $stable(av_rsp_o) && $stable(irq_o))
        else $error("state moved while clock enable low");
    reset_quiet_a: assert property (resetn_i && !$past(resetn_i)
        |-> av_rsp_o.waitrequest && !irq_o) else $error("outputs not idle after reset");
endmodule : rtc_spr_properties
bind rtc_spr rtc_spr_properties #(.NSEC_DROP_BITS(NSEC_DROP_BITS), .DCNT_BITS(DCNT_BITS)) props (
    .sys_clk_i, .resetn_i, .clk_en_i, .av_req_i, .av_rsp_o, .irq_o);
`default_nettype wire

// *** tb/rtc_pipe_model.sv ***
// pipeline model: issues register accesses as the bus master
`timescale 1ns/1ns
`default_nettype none
module rtc_pipe_model
    import rtc_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire rtc_pkg::av_rsp_t av_rsp_i,
    output var  rtc_pkg::av_req_t av_req_o
);
    initial av_req_o = '0;
    // request held until waitrequest is sampled low, so slow answers are tolerated
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        av_req_o <= '{address: a, read: !wr, write: wr, writedata: d};
        do @(posedge sys_clk_i); while (av_rsp_i.waitrequest !== 1'b0);
        q = av_rsp_i.readdata;
        av_req_o <= '0;
    endtask : xfer
endmodule : rtc_pipe_model
`default_nettype wire

// *** tb/rtc_spr_tb.sv ***
// testbench: clock words, move decode and interrupts through register accesses
`timescale 1ns/1ns
`default_nettype none
module rtc_spr_tb;
    import rtc_pkg::*;
    logic        sys_clk_i, resetn_i, clk_en_i, irq_o;
    av_req_t     av_req;
    av_rsp_t     av_rsp;
    logic [31:0] q;
    logic [31:0] t;
    int          num_errors = 0;
    int          compares = 0;
    rtc_spr dut (.sys_clk_i, .resetn_i, .clk_en_i, .av_req_i(av_req), .av_rsp_o(av_rsp), .irq_o);
    rtc_pipe_model pipe (.sys_clk_i, .av_rsp_i(av_rsp), .av_req_o(av_req));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        pipe.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        pipe.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    // data word first, then the command that executes the move; leaves the result in q
    task automatic mv(input logic sup, input logic wrt, input logic [9:0] n, input logic [31:0] d);
        wr(ADDR_WDATA, d);
        wr(ADDR_CMD, {14'h0, sup, wrt, 6'h0, n});
        rd(ADDR_RESULT);
    endtask : mv
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        num_errors++;
        finish_test();
    end
    initial begin
        resetn_i = 1'b0;
        clk_en_i = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(4'hf); chk(q, UNMAPPED_DATA);
        wr(ADDR_IRQ_EN, 32'h1);
        mv(1'b1, 1'b1, SPRN_SEC_WR, 32'h5); chk(q, 32'h1);
        mv(1'b1, 1'b1, SPRN_NSEC_WR, NSEC_LIMIT - 32'd19); chk(q, 32'h1);
        mv(1'b0, 1'b0, SPRN_SEC_RD, 32'h0); chk(q, 32'h1);
        rd(ADDR_RDATA); chk(q, 32'h6);
        chk({31'h0, irq_o}, 32'h1);
        rd(ADDR_NSEC); chk({31'h0, q < 32'd2000}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1); chk({31'h0, irq_o}, 32'h0);
        $display("test clock carry done");
        mv(1'b0, 1'b1, SPRN_SEC_WR, 32'h99); chk(q, 32'h4);
        mv(1'b0, 1'b1, SPRN_NSEC_WR, 32'h0); chk(q, 32'h6);
        chk({31'h0, irq_o}, 32'h0);
        rd(ADDR_IRQ_STAT); chk(q & 32'h4, 32'h4);
        wr(ADDR_IRQ_EN, 32'h4); chk({31'h0, irq_o}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h4); chk({31'h0, irq_o}, 32'h0);
        wr(ADDR_IRQ_EN, 32'h0);
        rd(ADDR_SECONDS); chk(q, 32'h6);
        mv(1'b0, 1'b0, SPRN_DCNT, 32'h0); chk(q, 32'h4);
        $display("test privilege done");
        mv(1'b0, 1'b1, SPRN_MQ, 32'h1234_5678); chk(q, 32'h1);
        mv(1'b0, 1'b0, 10'h3e0, 32'h0); chk(q, 32'h1);
        rd(ADDR_RDATA); chk(q, 32'h1234_5678);
        mv(1'b1, 1'b1, SPRN_DCNT, 32'h1000); chk(q, 32'h1);
        mv(1'b0, 1'b0, SPRN_DCNT_USER, 32'h0); chk(q, 32'h1);
        rd(ADDR_RDATA); chk({31'h0, q < 32'h1000}, 32'h1);
        chk(q % 32'd20, 32'd16);
        rd(ADDR_NSEC);
        t = q;
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
        rd(ADDR_NSEC); chk(q - t, 32'd4 * NSEC_STEP);
        $display("test moves done");
        finish_test();
    end
endmodule : rtc_spr_tb
`default_nettype wire
